// ===== inc/smrg_defines.svh
// Timing, width and pin-position constants for the sleep and reset gating block.
// Assumes the system clock period given here matches clk_sys.
`ifndef SMRG_DEFINES_SVH
`define SMRG_DEFINES_SVH

// System clock period in ns (25 MHz)
`define SMRG_CLK_PERIOD_NS 40

// Least low time on the reset pin that must give a reset, in ns
`define SMRG_RST_MIN_NS 1500
// Rounded up to whole clock cycles
`define SMRG_RST_MIN_CYC ((`SMRG_RST_MIN_NS + `SMRG_CLK_PERIOD_NS - 1) / `SMRG_CLK_PERIOD_NS)

// Least start-up time of a stopped oscillator, in ns
`define SMRG_OSC_START_NS 4000
// Rounded up to whole clock cycles
`define SMRG_OSC_START_CYC ((`SMRG_OSC_START_NS + `SMRG_CLK_PERIOD_NS - 1) / `SMRG_CLK_PERIOD_NS)

// Counter width, enough for both counts above
`define SMRG_CNT_W 8

// Four 8-bit ports, flattened as A[7:0], B[15:8], C[23:16], D[31:24]
`define SMRG_PORT_W 32
// Test-access pins on port C that keep their pull-ups through reset
`define SMRG_TDI_BIT 21
`define SMRG_TMS_BIT 19
`define SMRG_TCK_BIT 18

`endif

// ===== inc/smrg_pkg.sv
// Types shared by the sleep and reset gating block.
// Assumes smrg_defines.svh carries all numeric constants.
package smrg_pkg;

    // Software-selected sleep modes
    typedef enum logic [2:0] {
        SMRG_IDLE,
        SMRG_ADC_NR,
        SMRG_PWR_DOWN,
        SMRG_PWR_SAVE,
        SMRG_STANDBY,
        SMRG_EXT_STANDBY
    } smrg_mode_t;

    // Power sequencer states
    typedef enum logic [1:0] {
        SMRG_ST_RUN,
        SMRG_ST_SLEEP,
        SMRG_ST_WAKE,
        SMRG_ST_RESET
    } smrg_state_t;

endpackage

// ===== verilog/smrg_rst_filter.sv
// Reset pin qualifier: synchronises the pin and asserts a reset after a
// minimum low time. Assumes clk_sys runs free; the pad tristate path does
// not depend on this module.
`timescale 1ns/10ps
`include "smrg_defines.svh"
module smrg_rst_filter
    import smrg_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Reset pin, asynchronous
    input  wire logic rst_pin_n,
    // Qualified reset, level
    output logic      pin_rst
);

    typedef struct packed {
        logic                   s1;
        logic                   s2;
        logic [`SMRG_CNT_W-1:0] cnt;
        logic                   hit;
    } smrg_filt_t;

    smrg_filt_t st_ff;
    smrg_filt_t nxt_st;

    localparam logic [`SMRG_CNT_W-1:0] MIN_CYC = `SMRG_CNT_W'(`SMRG_RST_MIN_CYC);

    // Low-time counter saturates so a held pin keeps the reset on
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = rst_pin_n;
        nxt_st.s2 = st_ff.s1;
        if (!st_ff.s2) begin
            if (st_ff.cnt < MIN_CYC) begin
                nxt_st.cnt = st_ff.cnt + `SMRG_CNT_W'(1);
            end
        end else begin
            nxt_st.cnt = '0;
        end
        nxt_st.hit = (nxt_st.cnt >= MIN_CYC);
    end

    // Pin idles high, so the synchroniser resets high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '{s1: 1'b1, s2: 1'b1, cnt: '0, hit: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_rst = st_ff.hit;

    // A pin held low the full time must raise the reset next edge
    rst_long_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st_ff.s2 && st_ff.cnt == MIN_CYC - `SMRG_CNT_W'(1)) |=> pin_rst)
        else $error("long reset pulse not taken");

    // Short glitches never reach the reset
    rst_short_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(pin_rst) |-> $past(!st_ff.s2) && st_ff.cnt == MIN_CYC)
        else $error("reset raised before minimum low time");

endmodule

// ===== verilog/smrg_port_gate.sv
// Pad gating for the 32 general-purpose pins: output enables and pull-ups.
// Assumes pin_oe_req and pin_pull_req come from the port logic.
`timescale 1ns/10ps
`include "smrg_defines.svh"
module smrg_port_gate
    import smrg_pkg::*;
(
    // Clock and reset, used by checks only
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Reset condition
    input  wire logic                    rst_pin_n,
    input  wire logic                    chip_rst,
    input  wire logic                    jtag_en,
    // Port requests
    input  wire logic [`SMRG_PORT_W-1:0] pin_oe_req,
    input  wire logic [`SMRG_PORT_W-1:0] pin_pull_req,
    // Pads
    output logic      [`SMRG_PORT_W-1:0] pad_oe,
    output logic      [`SMRG_PORT_W-1:0] pad_pull_en
);

    logic in_rst;

    // Only these pins may keep a pull-up through reset, and only with test access on
    localparam logic [`SMRG_PORT_W-1:0] TAP_MASK = (`SMRG_PORT_W'(1) << `SMRG_TDI_BIT)
        | (`SMRG_PORT_W'(1) << `SMRG_TMS_BIT) | (`SMRG_PORT_W'(1) << `SMRG_TCK_BIT);

    // Raw pin path kept so pads float with no clock running
    assign in_rst = !rst_pin_n || chip_rst;

    // Per-pin gating
    genvar gi;
    generate
        for (gi = 0; gi < `SMRG_PORT_W; gi++) begin : g_pin
            localparam bit IS_TAP = (gi == `SMRG_TDI_BIT) || (gi == `SMRG_TMS_BIT)
                                 || (gi == `SMRG_TCK_BIT);
            assign pad_oe[gi] = pin_oe_req[gi] && !in_rst;
            if (IS_TAP) begin : g_tap
                assign pad_pull_en[gi] = (jtag_en) ? 1'b1
                                                   : (pin_pull_req[gi] && !in_rst);
            end else begin : g_gpio
                assign pad_pull_en[gi] = pin_pull_req[gi] && !in_rst;
            end
        end
    endgenerate

    pads_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        chip_rst |-> (pad_oe == '0)
                     && (pad_pull_en & ~(TAP_MASK & {`SMRG_PORT_W{jtag_en}})) == '0)
        else $error("pad driven during reset");

    tap_pullup_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (jtag_en && chip_rst) |-> pad_pull_en[`SMRG_TDI_BIT] && pad_pull_en[`SMRG_TMS_BIT]
                                  && pad_pull_en[`SMRG_TCK_BIT])
        else $error("test-access pull-up lost in reset");

endmodule

// ===== verilog/smrg_top.sv
// Sleep-mode sequencer and reset gating for an 8-bit controller.
// Assumes the CPU pulses sleep_req when it executes a sleep, and that the
// clock enables drive glitch-free gates downstream.
//
// Overview of operation
// - Six software-selected sleep modes gate clocks
// - Idle halts CPU, peripherals and interrupts run
// - Power-down stops oscillator, wakes on external/reset
// - Power-save keeps asynchronous timer running
// - Noise-reduction keeps only converter, asynchronous timer and oscillator
// - Standby keeps main oscillator running
// - Extended standby keeps oscillator and asynchronous timer
// - Long low reset pin gives reset
// - Port pins float while reset active
// - Test-access pull-ups stay on through reset
`timescale 1ns/10ps
`include "smrg_defines.svh"
module smrg_top
    import smrg_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Reset sources
    input  wire logic                    rst_pin_n,
    input  wire logic                    int_rst_req,
    // Sleep control from CPU
    input  wire logic                    sleep_req,
    input  wire smrg_mode_t              sleep_mode,
    // Wake sources
    input  wire logic                    ext_irq,
    input  wire logic                    atmr_irq,
    input  wire logic                    adc_irq,
    input  wire logic                    periph_irq,
    // Clock gating
    output logic                         cpu_clk_en,
    output logic                         io_clk_en,
    output logic                         adc_clk_en,
    output logic                         sram_clk_en,
    output logic                         atmr_clk_en,
    output logic                         osc_en,
    // Status
    output logic                         cpu_rst,
    output logic                         sleeping,
    output logic                         wake_pulse,
    // Pads
    input  wire logic                    jtag_en,
    input  wire logic [`SMRG_PORT_W-1:0] pin_oe_req,
    input  wire logic [`SMRG_PORT_W-1:0] pin_pull_req,
    output logic      [`SMRG_PORT_W-1:0] pad_oe,
    output logic      [`SMRG_PORT_W-1:0] pad_pull_en
);

    localparam logic [`SMRG_CNT_W-1:0] START_CYC = `SMRG_CNT_W'(`SMRG_OSC_START_CYC);

    typedef struct packed {
        smrg_state_t            state;
        smrg_mode_t             mode;
        logic                   irq_s1;
        logic                   irq_s2;
        logic [`SMRG_CNT_W-1:0] wcnt;
        logic                   cpu_clk_en;
        logic                   io_clk_en;
        logic                   adc_clk_en;
        logic                   sram_clk_en;
        logic                   atmr_clk_en;
        logic                   osc_en;
        logic                   cpu_rst;
        logic                   wake_pulse;
    } smrg_seq_t;

    smrg_seq_t st_ff;
    smrg_seq_t nxt_st;
    logic      pin_rst;
    logic      any_rst;
    logic      wake_hit;
    logic      osc_stopped;

    // Reset pin qualifier
    smrg_rst_filter u_rst_filter (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .rst_pin_n (rst_pin_n),
        .pin_rst   (pin_rst)
    );

    // Pad gating, also acts on the raw pin for the clockless case
    smrg_port_gate u_port_gate (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .rst_pin_n    (rst_pin_n),
        .chip_rst     (st_ff.cpu_rst),
        .jtag_en      (jtag_en),
        .pin_oe_req   (pin_oe_req),
        .pin_pull_req (pin_pull_req),
        .pad_oe       (pad_oe),
        .pad_pull_en  (pad_pull_en)
    );

    assign any_rst = pin_rst || int_rst_req;

    // Wake sources allowed in the selected mode
    always_comb begin
        case (st_ff.mode)
            SMRG_IDLE: begin
                wake_hit = st_ff.irq_s2 || atmr_irq || adc_irq || periph_irq;
            end
            SMRG_ADC_NR: begin
                wake_hit = st_ff.irq_s2 || atmr_irq || adc_irq;
            end
            SMRG_PWR_SAVE, SMRG_EXT_STANDBY: begin
                wake_hit = st_ff.irq_s2 || atmr_irq;
            end
            SMRG_PWR_DOWN, SMRG_STANDBY: begin
                wake_hit = st_ff.irq_s2;
            end
            default: begin
                wake_hit = st_ff.irq_s2;
            end
        endcase
    end

    // Stopped oscillator needs its start-up time; standby skips it
    assign osc_stopped = (st_ff.mode == SMRG_PWR_DOWN) || (st_ff.mode == SMRG_PWR_SAVE);

    // Sequencer and clock-gate decode
    always_comb begin
        logic sl;
        logic up;
        sl            = 1'b0;
        up            = 1'b0;
        nxt_st        = st_ff;
        nxt_st.irq_s1 = ext_irq;
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.wake_pulse = 1'b0;
        if (any_rst) begin
            nxt_st.state = SMRG_ST_RESET;
        end else begin
            case (st_ff.state)
                SMRG_ST_RUN: begin
                    if (sleep_req) begin
                        nxt_st.mode  = sleep_mode;
                        nxt_st.state = SMRG_ST_SLEEP;
                    end
                end
                SMRG_ST_SLEEP: begin
                    if (wake_hit) begin
                        nxt_st.state = SMRG_ST_WAKE;
                        nxt_st.wcnt  = osc_stopped ? START_CYC - `SMRG_CNT_W'(1) : '0;
                    end
                end
                SMRG_ST_WAKE: begin
                    // Contents untouched: no reset on the way back
                    if (st_ff.wcnt == '0) begin
                        nxt_st.state      = SMRG_ST_RUN;
                        nxt_st.wake_pulse = 1'b1;
                    end else begin
                        nxt_st.wcnt = st_ff.wcnt - `SMRG_CNT_W'(1);
                    end
                end
                SMRG_ST_RESET: begin
                    nxt_st.state = SMRG_ST_RUN;
                end
                default: begin
                    nxt_st.state = SMRG_ST_RESET;
                end
            endcase
        end
        sl = (nxt_st.state == SMRG_ST_SLEEP);
        up = (nxt_st.state == SMRG_ST_RUN) || (nxt_st.state == SMRG_ST_RESET);
        // CPU clocked in reset so the core's synchronous reset lands
        nxt_st.cpu_clk_en  = up;
        nxt_st.io_clk_en   = up || (sl && nxt_st.mode == SMRG_IDLE);
        nxt_st.sram_clk_en = up || (sl && nxt_st.mode == SMRG_IDLE);
        nxt_st.adc_clk_en  = up || (sl && (nxt_st.mode == SMRG_IDLE
                                        || nxt_st.mode == SMRG_ADC_NR));
        nxt_st.atmr_clk_en = !sl || nxt_st.mode == SMRG_IDLE
                          || nxt_st.mode == SMRG_ADC_NR
                          || nxt_st.mode == SMRG_PWR_SAVE
                          || nxt_st.mode == SMRG_EXT_STANDBY;
        // Oscillator on while waking so it can settle
        nxt_st.osc_en      = !sl || nxt_st.mode == SMRG_IDLE
                          || nxt_st.mode == SMRG_ADC_NR
                          || nxt_st.mode == SMRG_STANDBY
                          || nxt_st.mode == SMRG_EXT_STANDBY;
        nxt_st.cpu_rst     = (nxt_st.state == SMRG_ST_RESET);
    end

    // Block reset leaves the chip in reset with the main clocks on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '{state: SMRG_ST_RESET, mode: SMRG_IDLE, irq_s1: 1'b0, irq_s2: 1'b0,
                       wcnt: '0, cpu_clk_en: 1'b1, io_clk_en: 1'b1, adc_clk_en: 1'b1,
                       sram_clk_en: 1'b1, atmr_clk_en: 1'b1, osc_en: 1'b1,
                       cpu_rst: 1'b1, wake_pulse: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops; sleeping is decoded from the state flops
    assign cpu_clk_en  = st_ff.cpu_clk_en;
    assign io_clk_en   = st_ff.io_clk_en;
    assign adc_clk_en  = st_ff.adc_clk_en;
    assign sram_clk_en = st_ff.sram_clk_en;
    assign atmr_clk_en = st_ff.atmr_clk_en;
    assign osc_en      = st_ff.osc_en;
    assign cpu_rst     = st_ff.cpu_rst;
    assign wake_pulse  = st_ff.wake_pulse;
    assign sleeping    = (st_ff.state == SMRG_ST_SLEEP);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sleep_entry_a: assert property (
        (st_ff.state == SMRG_ST_RUN && sleep_req && !any_rst)
        |=> sleeping && st_ff.mode == $past(sleep_mode) && !cpu_clk_en)
        else $error("sleep request not taken");

    idle_gates_a: assert property (
        (sleeping && st_ff.mode == SMRG_IDLE)
        |-> !cpu_clk_en && io_clk_en && adc_clk_en && sram_clk_en && atmr_clk_en)
        else $error("idle gating wrong");

    pdown_gates_a: assert property (
        (sleeping && st_ff.mode == SMRG_PWR_DOWN)
        |-> !osc_en && !io_clk_en && !adc_clk_en && !atmr_clk_en && !sram_clk_en)
        else $error("power-down left a clock running");

    pdown_hold_a: assert property (
        (sleeping && st_ff.mode == SMRG_PWR_DOWN && !st_ff.irq_s2 && !any_rst)
        |=> sleeping)
        else $error("power-down left without external wake");

    psave_timer_a: assert property (
        (sleeping && st_ff.mode == SMRG_PWR_SAVE) |-> atmr_clk_en && !osc_en && !io_clk_en)
        else $error("power-save timer gating wrong");

    adc_nr_a: assert property (
        (sleeping && st_ff.mode == SMRG_ADC_NR)
        |-> adc_clk_en && atmr_clk_en && !io_clk_en && !cpu_clk_en)
        else $error("noise-reduction gating wrong");

    standby_osc_a: assert property (
        (sleeping && st_ff.mode == SMRG_STANDBY) |-> osc_en && !atmr_clk_en && !io_clk_en)
        else $error("standby oscillator gating wrong");

    ext_standby_a: assert property (
        (sleeping && st_ff.mode == SMRG_EXT_STANDBY) |-> osc_en && atmr_clk_en && !io_clk_en)
        else $error("extended standby gating wrong");

    reset_entry_a: assert property (
        any_rst |=> cpu_rst && !sleeping)
        else $error("reset source ignored");

    fast_wake_a: assert property (
        (sleeping && st_ff.mode == SMRG_STANDBY && st_ff.irq_s2 && !any_rst)
        ##1 !any_rst |=> cpu_clk_en && wake_pulse && !cpu_rst)
        else $error("standby wake not fast");

    wake_resume_a: assert property (
        (st_ff.state == SMRG_ST_WAKE && st_ff.wcnt == '0 && !any_rst)
        |=> cpu_clk_en && sram_clk_en && wake_pulse && !cpu_rst)
        else $error("wake did not restore clocks");

    // Waking: oscillator and timer settle, core still gated
    wake_gates_a: assert property (
        (st_ff.state == SMRG_ST_WAKE)
        |-> osc_en && atmr_clk_en && !cpu_clk_en
            && !io_clk_en && !sram_clk_en && !adc_clk_en)
        else $error("wake gating wrong");

    // Running: every clock on and the core out of reset
    run_gates_a: assert property (
        (st_ff.state == SMRG_ST_RUN)
        |-> cpu_clk_en && io_clk_en && adc_clk_en && sram_clk_en && atmr_clk_en && osc_en
            && !cpu_rst && !sleeping)
        else $error("run gating wrong");

    // Chip reset keeps the core clocked so its own reset lands
    reset_gates_a: assert property (
        (st_ff.state == SMRG_ST_RESET) |-> cpu_rst && cpu_clk_en && osc_en && !sleeping)
        else $error("reset gating wrong");

    // Mode is latched only in run; sleep requests elsewhere are dropped
    mode_hold_a: assert property (
        (st_ff.state != SMRG_ST_RUN) |=> st_ff.mode == $past(st_ff.mode))
        else $error("mode changed outside run");

    // Resume pulse lasts one cycle only
    pulse_once_a: assert property (
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse held");

    // A valid source in sleep starts the wake sequence next edge
    wake_entry_a: assert property (
        (sleeping && wake_hit && !any_rst) |=> st_ff.state == SMRG_ST_WAKE && osc_en)
        else $error("wake source not taken");

    // Oscillator start-up: the core stays gated until the count runs out
    osc_wait_a: assert property (
        (st_ff.state == SMRG_ST_WAKE && st_ff.wcnt != '0 && !any_rst)
        |=> st_ff.state == SMRG_ST_WAKE && !cpu_clk_en && !wake_pulse)
        else $error("core released before oscillator settled");

endmodule

// ===== sim/smrg_ext_model.sv
// Far-side model: external reset pin source and external interrupt line.
// Assumes the bench calls its tasks; lines change on the falling edge.
`timescale 1ns/10ps
module smrg_ext_model (
    // Clock
    input  wire logic clk_sys,
    // Driven lines
    output logic      rst_pin_n,
    output logic      ext_irq
);
    // Pin released high, interrupt idle low
    initial begin
        rst_pin_n = 1'b1;
        ext_irq   = 1'b0;
    end

    // Hold the pin low for n cycles; callers pass a short n to be ignored and a long one to reset
    task automatic pulse_rst(input int n);
        @(negedge clk_sys);
        rst_pin_n = 1'b0;
        repeat (n) @(negedge clk_sys);
        rst_pin_n = 1'b1;
    endtask

    // Level interrupt, held until the bench drops it
    task automatic set_irq(input logic v);
        ext_irq = v;
    endtask
endmodule

// ===== sim/smrg_top_tb.sv
// Self-checking bench for the sleep and reset gating block.
// Assumes smrg_ext_model drives the reset pin and external interrupt.
`timescale 1ns/10ps
`include "smrg_defines.svh"
module smrg_top_tb
    import smrg_pkg::*;
;
    logic                    clk_sys, rst_n, int_rst_req, sleep_req, jtag_en;
    logic                    rst_pin_n, ext_irq, atmr_irq, adc_irq, periph_irq;
    smrg_mode_t              sleep_mode;
    logic                    cpu_clk_en, io_clk_en, adc_clk_en, sram_clk_en;
    logic                    atmr_clk_en, osc_en, cpu_rst, sleeping, wake_pulse;
    logic [`SMRG_PORT_W-1:0] pin_oe_req, pin_pull_req, pad_oe, pad_pull_en;
    logic [5:0]              gates;
    int                      err_count, cmp_count, cyc;

    // Enables packed as cpu, io, adc, sram, async timer, oscillator
    assign gates = {cpu_clk_en, io_clk_en, adc_clk_en, sram_clk_en, atmr_clk_en, osc_en};

    smrg_top u_smrg_top (.clk_sys(clk_sys), .rst_n(rst_n), .rst_pin_n(rst_pin_n),
        .int_rst_req(int_rst_req), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
        .ext_irq(ext_irq), .atmr_irq(atmr_irq), .adc_irq(adc_irq),
        .periph_irq(periph_irq), .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
        .adc_clk_en(adc_clk_en), .sram_clk_en(sram_clk_en), .atmr_clk_en(atmr_clk_en),
        .osc_en(osc_en), .cpu_rst(cpu_rst), .sleeping(sleeping),
        .wake_pulse(wake_pulse), .jtag_en(jtag_en), .pin_oe_req(pin_oe_req),
        .pin_pull_req(pin_pull_req), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en));

    smrg_ext_model u_smrg_ext_model (.clk_sys(clk_sys), .rst_pin_n(rst_pin_n),
        .ext_irq(ext_irq));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Compare tasks, one per result width
    task automatic chk1(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %b got %b", nm, exp, got);
        end
    endtask
    task automatic chk6(input string nm, input logic [5:0] exp, input logic [5:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Source index: 1 external, 2 async timer, 3 converter, 4 peripheral
    task automatic set_src(input int s, input logic v);
        case (s)
            1: u_smrg_ext_model.set_irq(v);
            2: atmr_irq = v;
            3: adc_irq = v;
            4: periph_irq = v;
            default: ;
        endcase
    endtask

    // Bounded wait for the resume pulse; the long wake needs the oscillator count
    task automatic wait_wake();
        for (int i = 0; i < 150 && wake_pulse !== 1'b1; i++)
            @(negedge clk_sys);
        chk1("wake_pulse", 1'b1, wake_pulse);
    endtask

    task automatic enter_sleep(input smrg_mode_t m);
        sleep_mode = m;
        sleep_req  = 1'b1;
        @(negedge clk_sys);
        sleep_req  = 1'b0;
    endtask

    task automatic test_reset_vals();
        chk1("cpu_rst", 1'b0, cpu_rst);
        chk6("gates", 6'h3F, gates);
        chk1("sleeping", 1'b0, sleeping);
        chk32("pad_oe", pin_oe_req, pad_oe);
        $display("test reset_vals done");
    endtask

    // Every mode: gates, a source that must not wake (none driven for idle), then a valid wake
    task automatic test_modes();
        smrg_mode_t mt[6] = '{SMRG_IDLE, SMRG_ADC_NR, SMRG_PWR_DOWN, SMRG_PWR_SAVE,
                              SMRG_STANDBY, SMRG_EXT_STANDBY};
        logic [5:0] eg[6] = '{6'h1F, 6'h0B, 6'h00, 6'h02, 6'h01, 6'h03};
        int         bad[6] = '{0, 4, 2, 3, 2, 3};
        int         good[6] = '{4, 3, 1, 2, 1, 2};
        for (int i = 0; i < 6; i++) begin
            enter_sleep(mt[i]);
            chk1("sleeping", 1'b1, sleeping);
            chk6("sleep gates", eg[i], gates);
            set_src(bad[i], 1'b1);
            repeat (4) @(negedge clk_sys);
            chk1("still asleep", 1'b1, sleeping);
            set_src(bad[i], 1'b0);
            set_src(good[i], 1'b1);
            wait_wake();
            chk6("run gates", 6'h3F, gates);
            chk1("cpu_rst", 1'b0, cpu_rst);
            set_src(good[i], 1'b0);
            @(negedge clk_sys);
            chk1("awake", 1'b0, sleeping);
            chk1("wake_pulse end", 1'b0, wake_pulse);
        end
        $display("test modes done");
    endtask

    // Internal reset taken in deepest sleep overrides it
    task automatic test_int_reset();
        enter_sleep(SMRG_PWR_DOWN);
        @(negedge clk_sys);
        enter_sleep(SMRG_IDLE);
        chk6("refused gates", 6'h00, gates);
        int_rst_req = 1'b1;
        @(negedge clk_sys);
        int_rst_req = 1'b0;
        chk1("cpu_rst", 1'b1, cpu_rst);
        chk6("reset gates", 6'h3F, gates);
        chk32("pad_oe", 32'h0000_0000, pad_oe);
        repeat (2) @(negedge clk_sys);
        chk1("cpu_rst off", 1'b0, cpu_rst);
        chk32("pad_oe", pin_oe_req, pad_oe);
        $display("test int_reset done");
    endtask

    // Short pin pulse ignored but pads float; long one resets with JTAG pulls kept
    task automatic test_pin_reset();
        logic [31:0] jp;
        jp = (32'h0000_0001 << `SMRG_TDI_BIT) | (32'h0000_0001 << `SMRG_TMS_BIT)
           | (32'h0000_0001 << `SMRG_TCK_BIT);
        fork
            u_smrg_ext_model.pulse_rst(10);
            begin
                repeat (3) @(negedge clk_sys);
                chk32("pad_oe", 32'h0000_0000, pad_oe);
                chk32("pad_pull_en", 32'h0000_0000, pad_pull_en);
            end
        join
        repeat (3) @(negedge clk_sys);
        chk1("short pulse", 1'b0, cpu_rst);
        jtag_en = 1'b1;
        fork
            u_smrg_ext_model.pulse_rst(50);
            begin
                repeat (46) @(negedge clk_sys);
                chk1("cpu_rst", 1'b1, cpu_rst);
                chk32("pad_pull_en", jp, pad_pull_en);
                chk32("pad_oe", 32'h0000_0000, pad_oe);
            end
        join
        repeat (6) @(negedge clk_sys);
        chk1("cpu_rst off", 1'b0, cpu_rst);
        jtag_en = 1'b0;
        $display("test pin_reset done");
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc >= 5000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        err_count    = 0;
        cmp_count    = 0;
        cyc          = 0;
        rst_n        = 1'b0;
        int_rst_req  = 1'b0;
        sleep_req    = 1'b0;
        sleep_mode   = SMRG_IDLE;
        atmr_irq     = 1'b0;
        adc_irq      = 1'b0;
        periph_irq   = 1'b0;
        jtag_en      = 1'b0;
        pin_oe_req   = 32'hA5A5_5A5A;
        pin_pull_req = 32'hFFFF_FFFF;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        test_reset_vals();
        test_modes();
        test_int_reset();
        test_pin_reset();
        wrap_up();
    end
endmodule
